// [hw/ifd_decoder.sv]
// Instruction format decoder with two-word assembly, table unit and
// an AHB-Lite register slave.
// Assumes one instruction word per imem_valid_i pulse and a single bus master.
`timescale 1ns/10ps
`default_nettype none
// Notes on behaviour
// - Fast bit zero: no shadow save or restore; one: shadow copy pulse.
// - Relative branches give signed displacement; call and goto give absolute target; return gives no target.
// - Table pointer is 21 bits into program memory; table latch 8 bits.
// - Pre-increment mode advances the pointer before the access.
// - Indexed moves carry a 7-bit source offset and either a 7-bit destination offset or a 12-bit destination address.
// - Destination bit zero sends result to working register, one to file.
// - Access bit zero forces access bank, one uses bank select register.
// - Byte and bit operations take 8-bit file address from low byte.
// - File-to-file move: 12-bit source first word, destination second word.
// - Bit operations pick the bit with a 3-bit position field.
// - Literal operations take an 8-bit immediate from the low byte.
// - Call and goto target: low 8 bits first word, 12 bits second.
// - Unconditional relative branch uses an 11-bit displacement.
// - Conditional relative branches use an 8-bit displacement.
// - Don't-care bits are ignored whatever their value.
// - A lone second word decodes as a no-operation.
// - Table modes also include unchanged, post-increment and post-decrement.
module ifd_decoder (
	// Clock, reset and clock enable.
	input wire logic sys_clk_i,
	input wire logic reset_i,
	input wire logic clk_en_i,
	// Instruction words from program memory.
	input wire logic [ifd_pkg::WORD_W-1:0] imem_word_i,
	input wire logic imem_valid_i,
	// Decoded fields to the datapath.
	output var ifd_pkg::ifd_decode_t decoded_o,
	// Table access to program memory.
	output logic [ifd_pkg::PTR_W-1:0] tbl_addr_o,
	output logic tbl_rd_o,
	output logic tbl_wr_o,
	output logic [ifd_pkg::BYTE_W-1:0] tbl_wdata_o,
	input wire logic [ifd_pkg::BYTE_W-1:0] tbl_rdata_i,
	// AHB-Lite register slave.
	input wire logic hsel_i,
	input wire logic [ifd_pkg::DATA_W-1:0] haddr_i,
	input wire logic [1:0] htrans_i,
	input wire logic hwrite_i,
	input wire logic [2:0] hsize_i,
	input wire logic [ifd_pkg::DATA_W-1:0] hwdata_i,
	input wire logic hready_i,
	output logic [ifd_pkg::DATA_W-1:0] hrdata_o,
	output logic hreadyout_o,
	output logic hresp_o
);
	import ifd_pkg::*;

	typedef struct packed {
		ifd_state_t state;
		logic [WORD_W-1:0] first;
		ifd_class_t pcls;
		ifd_decode_t dec;
		logic [1:0] ctrl;
		logic [CNT_W-1:0] err_cnt;
		logic [CNT_W-1:0] dec_cnt;
		logic [WORD_W-1:0] last_word;
		logic ahb_wr;
		logic [REG_AW-1:0] ahb_addr;
		logic [DATA_W-1:0] hrdata;
		logic hready;
		logic hresp;
	} ifd_top_st_t;

	ifd_top_st_t s_q;
	ifd_top_st_t s_d;
	ifd_fields_t f;
	ifd_class_t cls_w;
	ifd_decode_t dec;
	ifd_decode_t dec2;
	logic [NIB_W-1:0] nib;
	logic take;
	logic first_take;
	logic two_word;
	logic tbl_go;
	logic ahb_acc;
	logic ptr_load;
	logic lat_load;
	logic [PTR_W-1:0] tbl_ptr;
	logic [BYTE_W-1:0] tbl_lat;
	logic [DATA_W-1:0] rd_mux;

	ifd_field_split u_split (
		.word_i(imem_word_i),
		.fields_o(f)
	);

	ifd_table_unit u_table (
		.sys_clk_i(sys_clk_i),
		.reset_i(reset_i),
		.clk_en_i(clk_en_i),
		.go_i(tbl_go),
		.mode_i(dec.tbl_mode),
		.write_i(dec.tbl_write),
		.ptr_load_i(ptr_load),
		.lat_load_i(lat_load),
		.sw_data_i(hwdata_i[PTR_W-1:0]),
		.rdata_i(tbl_rdata_i),
		.ptr_o(tbl_ptr),
		.lat_o(tbl_lat),
		.addr_o(tbl_addr_o),
		.rd_o(tbl_rd_o),
		.wr_o(tbl_wr_o)
	);

	assign nib = imem_word_i[WORD_W-1 -: NIB_W];
	assign take = clk_en_i && imem_valid_i && s_q.ctrl[CTRL_EN_BIT];
	assign first_take = take && s_q.state == ST_FIRST;
	assign ahb_acc = hsel_i && htrans_i[HTRANS_ACT] && hready_i;
	assign ptr_load = s_q.ahb_wr && s_q.ahb_addr == REG_TPTR;
	assign lat_load = s_q.ahb_wr && s_q.ahb_addr == REG_TLAT;
	assign two_word = cls_w == CLS_FILE_TO_FILE_MOVE || cls_w == CLS_GOTO || cls_w == CLS_CALL
		|| cls_w == CLS_IDX;

	// Sorts the word into its format from the opcode bits.
	always_comb begin
		cls_w = CLS_OTHER;
		case (nib)
			NIB_SECOND: cls_w = CLS_NOP;
			NIB_FILE_TO_FILE_MOVE: cls_w = CLS_FILE_TO_FILE_MOVE;
			NIB_BRANCH: cls_w = imem_word_i[BRA_W] ? CLS_RCALL : CLS_BRA;
			NIB_CTRL: begin
				if (!imem_word_i[BRA_W]) begin
					cls_w = CLS_COND;
				end else if (imem_word_i[BRA_W -: NIB_W] == CTRL_GOTO) begin
					cls_w = CLS_GOTO;
				end else if (imem_word_i[BRA_W -: 3] == CTRL_CALL) begin
					cls_w = CLS_CALL;
				end else if (imem_word_i[BRA_W -: NIB_W] == CTRL_IDX) begin
					cls_w = CLS_IDX;
				end
			end
			NIB_MISC: begin
				if (imem_word_i[BRA_W]
					|| (imem_word_i[POS_ACCESS] && !(|imem_word_i[POS_DEST +: 2]))) begin
					cls_w = CLS_LIT;
				end else if (|imem_word_i[BRA_W -: 3]) begin
					cls_w = CLS_BYTE;
				end else if (imem_word_i[BYTE_W-1:3] == TBL_PREFIX) begin
					cls_w = CLS_TABLE;
				end else if (imem_word_i[BYTE_W-1:2] == RET_PREFIX) begin
					cls_w = CLS_RETURN;
				end
			end
			default: begin
				cls_w = (nib >= NIB_BIT_LO && nib <= NIB_BIT_HI) ? CLS_BIT : CLS_BYTE;
			end
		endcase
	end

	// Single-word decode and completion of a two-word pair.
	always_comb begin
		dec = '0;
		dec.valid = 1'b1;
		dec.cls = cls_w;
		case (cls_w)
			CLS_BYTE: begin
				dec.file_addr = f.file_addr;
				dec.to_file = f.to_file;
				dec.use_bsr = f.use_bsr;
			end
			CLS_BIT: begin
				dec.file_addr = f.file_addr;
				dec.use_bsr = f.use_bsr;
				dec.bit_pos = f.bit_pos;
			end
			CLS_LIT: dec.literal = f.literal;
			CLS_BRA, CLS_RCALL: begin
				dec.target = {{(PTR_W-BRA_W){f.disp11[BRA_W-1]}}, f.disp11};
				dec.relative = 1'b1;
			end
			CLS_COND: begin
				dec.target = {{(PTR_W-BYTE_W){f.disp8[BYTE_W-1]}}, f.disp8};
				dec.relative = 1'b1;
			end
			CLS_RETURN: dec.shadow_restore = f.ret_fast;
			CLS_TABLE: begin
				dec.tbl_mode = f.tbl_mode;
				dec.tbl_write = f.tbl_write;
			end
			default: dec.valid = 1'b1;
		endcase
		dec2 = '0;
		dec2.valid = 1'b1;
		dec2.cls = s_q.pcls;
		case (s_q.pcls)
			CLS_FILE_TO_FILE_MOVE: begin
				dec2.src_addr = s_q.first[ADDR12_W-1:0];
				dec2.dst_addr = imem_word_i[ADDR12_W-1:0];
			end
			CLS_GOTO, CLS_CALL: begin
				dec2.target = {{(PTR_W-TGT_W){1'b0}}, imem_word_i[ADDR12_W-1:0],
					s_q.first[BYTE_W-1:0]};
				dec2.shadow_save = s_q.pcls == CLS_CALL && s_q.first[POS_CALL_FAST];
			end
			CLS_IDX: begin
				dec2.src_off = s_q.first[OFF_W-1:0];
				dec2.dst_is_off = s_q.first[POS_IDX_SEL];
				if (s_q.first[POS_IDX_SEL]) begin
					dec2.dst_off = imem_word_i[OFF_W-1:0];
				end else begin
					dec2.dst_addr = imem_word_i[ADDR12_W-1:0];
				end
			end
			default: dec2.cls = CLS_OTHER;
		endcase
	end

	// Register read view.
	always_comb begin
		rd_mux = '0;
		case (haddr_i[REG_AW-1:0])
			REG_CTRL: rd_mux[1:0] = s_q.ctrl;
			REG_STATUS: begin
				rd_mux[0] = s_q.state == ST_SECOND;
				rd_mux[STAT_CLS_LSB +: CLS_W] = s_q.dec.cls;
				rd_mux[STAT_ERR_LSB +: CNT_W] = s_q.err_cnt;
				rd_mux[STAT_CNT_LSB +: CNT_W] = s_q.dec_cnt;
			end
			REG_TPTR: rd_mux[PTR_W-1:0] = tbl_ptr;
			REG_TLAT: rd_mux[BYTE_W-1:0] = tbl_lat;
			REG_WORD: rd_mux[WORD_W-1:0] = s_q.last_word;
			REG_TARGET: rd_mux[PTR_W-1:0] = s_q.dec.target;
			default: rd_mux = '0;
		endcase
	end

	// Next state of the decoder and the bus slave.
	always_comb begin
		s_d = s_q;
		s_d.dec.valid = 1'b0;
		s_d.dec.shadow_save = 1'b0;
		s_d.dec.shadow_restore = 1'b0;
		s_d.dec.tbl_mode = TBL_NONE;
		tbl_go = 1'b0;
		if (take) begin
			s_d.last_word = imem_word_i;
			case (s_q.state)
				ST_FIRST: begin
					if (two_word) begin
						s_d.state = ST_SECOND;
						s_d.first = imem_word_i;
						s_d.pcls = cls_w;
					end else begin
						s_d.dec = dec;
						s_d.dec_cnt = s_q.dec_cnt + CNT_W'(1);
						tbl_go = cls_w == CLS_TABLE;
					end
				end
				ST_SECOND: begin
					s_d.state = ST_FIRST;
					if (nib == NIB_SECOND) begin
						s_d.dec = dec2;
						s_d.dec_cnt = s_q.dec_cnt + CNT_W'(1);
					end else begin
						s_d.dec = '0;
						s_d.dec.valid = 1'b1;
						s_d.err_cnt = s_q.err_cnt + CNT_W'(1);
					end
				end
				default: s_d.state = ST_FIRST;
			endcase
		end
		s_d.ahb_wr = ahb_acc && hwrite_i;
		s_d.ahb_addr = haddr_i[REG_AW-1:0];
		s_d.hready = 1'b1;
		s_d.hresp = 1'b0;
		if (ahb_acc && !hwrite_i) begin
			s_d.hrdata = rd_mux;
		end
		if (s_q.ahb_wr && s_q.ahb_addr == REG_CTRL) begin
			s_d.ctrl[CTRL_EN_BIT] = hwdata_i[CTRL_EN_BIT];
			if (hwdata_i[CTRL_CLR_BIT]) begin
				s_d.err_cnt = '0;
				s_d.dec_cnt = '0;
			end
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			s_q <= '0;
			s_q.state <= ST_FIRST;
			s_q.ctrl <= CTRL_RST;
			s_q.hready <= 1'b1;
		end else if (clk_en_i) begin
			s_q <= s_d;
		end
	end

	assign decoded_o = s_q.dec;
	assign tbl_wdata_o = tbl_lat;
	assign hrdata_o = s_q.hrdata;
	assign hreadyout_o = s_q.hready;
	assign hresp_o = s_q.hresp;

	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (reset_i);

	AST_FILE_ADDR: assert property (
		first_take && (cls_w == CLS_BYTE || cls_w == CLS_BIT)
		|=> decoded_o.valid && decoded_o.file_addr == $past(imem_word_i[BYTE_W-1:0]))
		else $error("File address does not follow the low byte.");
	AST_DEST_BIT: assert property (
		first_take && cls_w == CLS_BYTE |=> decoded_o.to_file == $past(imem_word_i[POS_DEST]))
		else $error("Destination select does not follow the word.");
	AST_ACCESS_BIT: assert property (
		first_take && cls_w == CLS_BIT |=> decoded_o.use_bsr == $past(imem_word_i[POS_ACCESS]))
		else $error("Bank choice does not follow the access bit.");
	AST_BIT_POS: assert property (
		first_take && cls_w == CLS_BIT
		|=> decoded_o.bit_pos == $past(imem_word_i[POS_BIT +: BITPOS_W]))
		else $error("Bit position is wrong.");
	AST_LITERAL: assert property (
		first_take && cls_w == CLS_LIT |=> decoded_o.literal == $past(imem_word_i[BYTE_W-1:0]))
		else $error("Literal is not the low byte.");
	AST_BRA_DISP: assert property (
		first_take && cls_w == CLS_BRA |=> decoded_o.relative
		&& $signed(decoded_o.target) == $signed($past(imem_word_i[BRA_W-1:0])))
		else $error("Long relative displacement is wrong.");
	AST_COND_DISP: assert property (
		first_take && cls_w == CLS_COND |=> decoded_o.relative
		&& $signed(decoded_o.target) == $signed($past(imem_word_i[BYTE_W-1:0])))
		else $error("Short relative displacement is wrong.");
	AST_RET_FAST: assert property (
		first_take && cls_w == CLS_RETURN
		|=> decoded_o.shadow_restore == $past(imem_word_i[POS_RET_FAST]) && !decoded_o.shadow_save)
		else $error("Return shadow restore does not follow the fast bit.");
	AST_SHADOW_ONLY: assert property (
		decoded_o.shadow_save |-> decoded_o.cls == CLS_CALL && !decoded_o.relative)
		else $error("Shadow save outside a fast call.");
	AST_LONE_SECOND: assert property (
		first_take && nib == NIB_SECOND |=> decoded_o.valid && decoded_o.cls == CLS_NOP
		&& !decoded_o.shadow_save && decoded_o.tbl_mode == TBL_NONE)
		else $error("Lone second word is not a no-operation.");
	AST_LONG_TARGET: assert property (
		take && s_q.state == ST_SECOND && nib == NIB_SECOND
		&& (s_q.pcls == CLS_GOTO || s_q.pcls == CLS_CALL)
		|=> !decoded_o.relative && decoded_o.target[TGT_W-1:0]
		== {$past(imem_word_i[ADDR12_W-1:0]), $past(s_q.first[BYTE_W-1:0])})
		else $error("Two-word target is assembled wrong.");
	AST_MOVE_PAIR: assert property (
		take && s_q.state == ST_SECOND && nib == NIB_SECOND && s_q.pcls == CLS_FILE_TO_FILE_MOVE
		|=> decoded_o.src_addr == $past(s_q.first[ADDR12_W-1:0])
		&& decoded_o.dst_addr == $past(imem_word_i[ADDR12_W-1:0]))
		else $error("File-to-file move addresses are wrong.");
	AST_ONE_CYCLE: assert property (
		first_take && !two_word |=> decoded_o.valid ##1 !decoded_o.valid || $past(take))
		else $error("Decoded fields did not appear one edge after the word.");
endmodule // ifd_decoder
`default_nettype wire

// [hw/ifd_field_split.sv]
// Combinational extraction of the raw operand fields of one instruction word.
// Assumes the caller picks the fields that belong to the word's format.
`timescale 1ns/10ps
`default_nettype none
module ifd_field_split (
	// Instruction word in.
	input wire logic [ifd_pkg::WORD_W-1:0] word_i,
	// Raw fields out.
	output var ifd_pkg::ifd_fields_t fields_o
);
	import ifd_pkg::*;

	always_comb begin
		fields_o = '0;
		fields_o.file_addr = word_i[BYTE_W-1:0];
		fields_o.to_file = word_i[POS_DEST];
		fields_o.use_bsr = word_i[POS_ACCESS];
		fields_o.bit_pos = word_i[POS_BIT +: BITPOS_W];
		fields_o.literal = word_i[BYTE_W-1:0];
		fields_o.disp11 = word_i[BRA_W-1:0];
		fields_o.disp8 = word_i[BYTE_W-1:0];
		fields_o.ret_fast = word_i[POS_RET_FAST];
		fields_o.tbl_mode = word_i[MODE_W-1:0];
		fields_o.tbl_write = word_i[POS_TBL_WR];
	end
endmodule // ifd_field_split
`default_nettype wire

// [hw/ifd_pkg.sv]
// Shared widths, field positions, encodings, register map and types of the
// instruction format decoder.
// Assumes 16-bit instruction words and a 32-bit AHB-Lite register bus.
package ifd_pkg;
	localparam int unsigned WORD_W = 16;
	localparam int unsigned NIB_W = 4;
	localparam int unsigned BYTE_W = 8;
	localparam int unsigned BITPOS_W = 3;
	localparam int unsigned ADDR12_W = 12;
	localparam int unsigned OFF_W = 7;
	localparam int unsigned BRA_W = 11;
	localparam int unsigned TGT_W = 20;
	localparam int unsigned PTR_W = 21;
	localparam int unsigned MODE_W = 2;
	localparam int unsigned CLS_W = 4;
	localparam int unsigned CNT_W = 8;
	localparam int unsigned DATA_W = 32;
	localparam int unsigned REG_AW = 8;
	localparam int unsigned POS_DEST = 9;
	localparam int unsigned POS_ACCESS = 8;
	localparam int unsigned POS_BIT = 9;
	localparam int unsigned POS_CALL_FAST = 8;
	localparam int unsigned POS_RET_FAST = 0;
	localparam int unsigned POS_TBL_WR = 2;
	localparam int unsigned POS_IDX_SEL = 7;
	localparam int unsigned HTRANS_ACT = 1;
	localparam logic [3:0] NIB_SECOND = 4'hf;
	localparam logic [3:0] NIB_FILE_TO_FILE_MOVE = 4'hc;
	localparam logic [3:0] NIB_BRANCH = 4'hd;
	localparam logic [3:0] NIB_CTRL = 4'he;
	localparam logic [3:0] NIB_MISC = 4'h0;
	localparam logic [3:0] NIB_BIT_LO = 4'h7;
	localparam logic [3:0] NIB_BIT_HI = 4'hb;
	localparam logic [3:0] CTRL_GOTO = 4'hf;
	localparam logic [2:0] CTRL_CALL = 3'h6;
	localparam logic [3:0] CTRL_IDX = 4'hb;
	localparam logic [4:0] TBL_PREFIX = 5'h01;
	localparam logic [5:0] RET_PREFIX = 6'h04;
	localparam logic [1:0] TBL_NONE = 2'h0;
	localparam logic [1:0] TBL_POST_INC = 2'h1;
	localparam logic [1:0] TBL_POST_DEC = 2'h2;
	localparam logic [1:0] TBL_PRE_INC = 2'h3;
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam logic [7:0] REG_TPTR = 8'h08;
	localparam logic [7:0] REG_TLAT = 8'h0c;
	localparam logic [7:0] REG_WORD = 8'h10;
	localparam logic [7:0] REG_TARGET = 8'h14;
	localparam int unsigned CTRL_EN_BIT = 0;
	localparam int unsigned CTRL_CLR_BIT = 1;
	localparam logic [1:0] CTRL_RST = 2'h1;
	localparam int unsigned STAT_CLS_LSB = 4;
	localparam int unsigned STAT_ERR_LSB = 8;
	localparam int unsigned STAT_CNT_LSB = 16;

	typedef enum logic [CLS_W-1:0] {
		CLS_OTHER = 4'h0, CLS_NOP = 4'h1, CLS_BYTE = 4'h2, CLS_BIT = 4'h3,
		CLS_LIT = 4'h4, CLS_FILE_TO_FILE_MOVE = 4'h5, CLS_BRA = 4'h6, CLS_RCALL = 4'h7,
		CLS_COND = 4'h8, CLS_GOTO = 4'h9, CLS_CALL = 4'ha, CLS_RETURN = 4'hb,
		CLS_TABLE = 4'hc, CLS_IDX = 4'hd
	} ifd_class_t;

	typedef enum logic [1:0] {ST_FIRST = 2'b01, ST_SECOND = 2'b10} ifd_state_t;

	typedef struct packed {
		logic [BYTE_W-1:0] file_addr;
		logic to_file;
		logic use_bsr;
		logic [BITPOS_W-1:0] bit_pos;
		logic [BYTE_W-1:0] literal;
		logic [BRA_W-1:0] disp11;
		logic [BYTE_W-1:0] disp8;
		logic ret_fast;
		logic [MODE_W-1:0] tbl_mode;
		logic tbl_write;
	} ifd_fields_t;

	typedef struct packed {
		logic valid;
		ifd_class_t cls;
		logic [BYTE_W-1:0] file_addr;
		logic to_file;
		logic use_bsr;
		logic [BITPOS_W-1:0] bit_pos;
		logic [BYTE_W-1:0] literal;
		logic [ADDR12_W-1:0] src_addr;
		logic [ADDR12_W-1:0] dst_addr;
		logic [OFF_W-1:0] src_off;
		logic [OFF_W-1:0] dst_off;
		logic dst_is_off;
		logic [PTR_W-1:0] target;
		logic relative;
		logic shadow_save;
		logic shadow_restore;
		logic [MODE_W-1:0] tbl_mode;
		logic tbl_write;
	} ifd_decode_t;
endpackage

// [hw/ifd_table_unit.sv]
// Table pointer and table data latch with the four pointer modes.
// Assumes program memory returns read data in the same cycle as rd_o.
`timescale 1ns/10ps
`default_nettype none
module ifd_table_unit #(
	parameter int unsigned PTR_WIDTH = ifd_pkg::PTR_W,
	parameter int unsigned LAT_WIDTH = ifd_pkg::BYTE_W
) (
	// Clock, reset and clock enable.
	input wire logic sys_clk_i,
	input wire logic reset_i,
	input wire logic clk_en_i,
	// Table operation from the decoder.
	input wire logic go_i,
	input wire logic [ifd_pkg::MODE_W-1:0] mode_i,
	input wire logic write_i,
	// Software loads.
	input wire logic ptr_load_i,
	input wire logic lat_load_i,
	input wire logic [PTR_WIDTH-1:0] sw_data_i,
	// Program memory side.
	input wire logic [LAT_WIDTH-1:0] rdata_i,
	output logic [PTR_WIDTH-1:0] ptr_o,
	output logic [LAT_WIDTH-1:0] lat_o,
	output logic [PTR_WIDTH-1:0] addr_o,
	output logic rd_o,
	output logic wr_o
);
	import ifd_pkg::*;

	typedef struct packed {
		logic [PTR_WIDTH-1:0] ptr;
		logic [LAT_WIDTH-1:0] lat;
		logic [PTR_WIDTH-1:0] addr;
		logic rd;
		logic wr;
	} ifd_tbl_st_t;

	ifd_tbl_st_t s_q;
	ifd_tbl_st_t s_d;

	always_comb begin
		s_d = s_q;
		s_d.rd = 1'b0;
		s_d.wr = 1'b0;
		if (ptr_load_i) begin
			s_d.ptr = sw_data_i;
		end
		if (lat_load_i) begin
			s_d.lat = sw_data_i[LAT_WIDTH-1:0];
		end
		if (s_q.rd) begin
			s_d.lat = rdata_i;
		end
		if (go_i) begin
			s_d.addr = (mode_i == TBL_PRE_INC) ? s_q.ptr + PTR_WIDTH'(1) : s_q.ptr;
			s_d.rd = !write_i;
			s_d.wr = write_i;
			case (mode_i)
				TBL_POST_INC, TBL_PRE_INC: s_d.ptr = s_q.ptr + PTR_WIDTH'(1);
				TBL_POST_DEC: s_d.ptr = s_q.ptr - PTR_WIDTH'(1);
				default: s_d.ptr = s_q.ptr;
			endcase
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			s_q <= '0;
		end else if (clk_en_i) begin
			s_q <= s_d;
		end
	end

	assign ptr_o = s_q.ptr;
	assign lat_o = s_q.lat;
	assign addr_o = s_q.addr;
	assign rd_o = s_q.rd;
	assign wr_o = s_q.wr;

	AST_PRE_INC: assert property (@(posedge sys_clk_i) disable iff (reset_i)
		clk_en_i && go_i && mode_i == TBL_PRE_INC |=> addr_o == $past(ptr_o) + PTR_WIDTH'(1)
		&& ptr_o == addr_o)
		else $error("Pre-increment access did not use the advanced pointer.");
	AST_POST_MODES: assert property (@(posedge sys_clk_i) disable iff (reset_i)
		clk_en_i && go_i && mode_i != TBL_PRE_INC |=> addr_o == $past(ptr_o)
		&& (rd_o || wr_o))
		else $error("Post mode access did not use the old pointer.");
endmodule // ifd_table_unit
`default_nettype wire

// [sim/ifd_decoder_bench.sv]
// Testbench for the instruction format decoder: decode, table and bus tests.
// Assumes the program memory model supplies words and table read data.
`timescale 1ns/10ps
`default_nettype none
module ifd_decoder_bench;
	import ifd_pkg::*;
	logic clk;
	logic rst;
	logic [15:0] word;
	logic wvalid;
	ifd_decode_t dec;
	logic [20:0] taddr;
	logic trd;
	logic twr;
	logic [7:0] twdata;
	logic [7:0] trdata;
	logic hsel;
	logic [31:0] haddr;
	logic [1:0] htrans;
	logic hwrite;
	logic [2:0] hsize;
	logic [31:0] hwdata;
	logic [31:0] hrdata;
	logic hrdy;
	logic hresp;
	logic [31:0] rd;
	logic [20:0] p;
	int err_count;
	int comparisons;
	ifd_decoder uut (.sys_clk_i(clk), .reset_i(rst), .clk_en_i(1'b1), .imem_word_i(word),
		.imem_valid_i(wvalid), .decoded_o(dec), .tbl_addr_o(taddr), .tbl_rd_o(trd),
		.tbl_wr_o(twr), .tbl_wdata_o(twdata), .tbl_rdata_i(trdata), .hsel_i(hsel),
		.haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize),
		.hwdata_i(hwdata), .hready_i(hrdy), .hrdata_o(hrdata), .hreadyout_o(hrdy),
		.hresp_o(hresp));
	ifd_imem_model m (.sys_clk_i(clk), .tbl_addr_i(taddr), .tbl_rd_i(trd),
		.tbl_rdata_o(trdata), .word_o(word), .valid_o(wvalid));
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
		comparisons++;
		if (s !== e) begin
			err_count++;
			$display("ERROR %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic final_report();
		$display("comparisons %0d mismatches %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		hsel <= 1'b1;
		haddr <= {24'h000000, a};
		htrans <= 2'h2;
		hwrite <= w;
		@(posedge clk);
		while (hrdy !== 1'b1) @(posedge clk);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge clk);
		while (hrdy !== 1'b1) @(posedge clk);
		rd = hrdata;
	endtask
	// A nonzero first word makes a two-word pair.
	task automatic dx(input logic [15:0] w1, input logic [15:0] w2, input ifd_class_t c);
		if (w1 !== 16'h0000) m.send(w1);
		m.send(w2);
		#1;
		chk("valid", dec.valid, 1'b1);
		chk("class", dec.cls, c);
	endtask
	initial begin
		#200000;
		err_count++;
		final_report();
	end
	initial begin
		rst = 1'b1;
		hsel = 1'b0;
		haddr = 32'h00000000;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h00000000;
		err_count = 0;
		comparisons = 0;
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		#1;
		chk("valid", dec.valid, 1'b0);
		chk("tbl_rd", trd, 1'b0);
		chk("hresp", hresp, 1'b0);
		chk("hready", hrdy, 1'b1);
		$display("test reset done");
		dx(0, 16'h27a5, CLS_BYTE);
		chk("to_file", dec.to_file, 1'b1);
		chk("use_bsr", dec.use_bsr, 1'b1);
		chk("file", dec.file_addr, 8'ha5);
		dx(0, 16'h2418, CLS_BYTE);
		chk("to_file", dec.to_file, 1'b0);
		chk("use_bsr", dec.use_bsr, 1'b0);
		dx(0, 16'h0745, CLS_BYTE);
		chk("to_file", dec.to_file, 1'b1);
		chk("use_bsr", dec.use_bsr, 1'b1);
		chk("file", dec.file_addr, 8'h45);
		dx(0, 16'h8b3c, CLS_BIT);
		chk("bit_pos", dec.bit_pos, 3'h5);
		chk("file", dec.file_addr, 8'h3c);
		dx(0, 16'h0f7f, CLS_LIT);
		chk("literal", dec.literal, 8'h7f);
		dx(0, 16'hd3ff, CLS_BRA);
		chk("target", dec.target, 21'h0003ff);
		dx(0, 16'hd400, CLS_BRA);
		chk("target", dec.target, 21'h1ffc00);
		chk("relative", dec.relative, 1'b1);
		dx(0, 16'hdc01, CLS_RCALL);
		chk("target", dec.target, 21'h1ffc01);
		chk("relative", dec.relative, 1'b1);
		dx(0, 16'he280, CLS_COND);
		chk("target", dec.target, 21'h1fff80);
		dx(16'hef12, 16'hf345, CLS_GOTO);
		chk("target", dec.target, 21'h034512);
		chk("relative", dec.relative, 1'b0);
		dx(16'hed12, 16'hf345, CLS_CALL);
		chk("shadow_save", dec.shadow_save, 1'b1);
		dx(16'hec34, 16'hfabc, CLS_CALL);
		chk("shadow_save", dec.shadow_save, 1'b0);
		chk("target", dec.target, 21'h0abc34);
		dx(0, 16'h0013, CLS_RETURN);
		chk("shadow_restore", dec.shadow_restore, 1'b1);
		dx(0, 16'h0012, CLS_RETURN);
		chk("shadow_restore", dec.shadow_restore, 1'b0);
		dx(16'hc123, 16'hf456, CLS_FILE_TO_FILE_MOVE);
		chk("src", dec.src_addr, 12'h123);
		chk("dst", dec.dst_addr, 12'h456);
		dx(16'heb05, 16'hf789, CLS_IDX);
		chk("src_off", dec.src_off, 7'h05);
		chk("dst", dec.dst_addr, 12'h789);
		dx(16'heb85, 16'hfffa, CLS_IDX);
		chk("dst_off", dec.dst_off, 7'h7a);
		chk("dst_is_off", dec.dst_is_off, 1'b1);
		dx(0, 16'hf123, CLS_NOP);
		dx(16'hef12, 16'h0f7f, CLS_OTHER);
		bus(1'b0, REG_STATUS, 32'h00000000);
		chk("pending", rd[0], 1'b0);
		chk("err_cnt", rd[15:8], 8'h01);
		chk("dec_cnt", rd[23:16], 8'h12);
		bus(1'b1, REG_CTRL, 32'h00000003);
		bus(1'b0, REG_STATUS, 32'h00000000);
		chk("counters", rd[23:8], 16'h0000);
		$display("test decode done");
		bus(1'b1, REG_TPTR, 32'hffffffff);
		bus(1'b0, REG_TPTR, 32'h00000000);
		chk("tptr", rd, 32'h001fffff);
		bus(1'b1, REG_TPTR, 32'h00000100);
		p = 21'h000100;
		for (int i = 0; i < 4; i++) begin
			m.send(16'h0008 | 16'(i));
			#1;
			if (i == 3) p++;
			chk("tbl_rd", trd, 1'b1);
			chk("tbl_mode", dec.tbl_mode, i);
			chk("tbl_addr", taddr, p);
			if (i == 1) p++;
			if (i == 2) p--;
		end
		bus(1'b0, REG_TPTR, 32'h00000000);
		chk("tptr", rd, {11'h000, p});
		bus(1'b0, REG_TLAT, 32'h00000000);
		chk("tlat", rd, 32'h0000005b);
		m.send(16'h000c);
		#1;
		chk("tbl_wr", twr, 1'b1);
		chk("tbl_write", dec.tbl_write, 1'b1);
		chk("tbl_wdata", twdata, 8'h5b);
		chk("tbl_addr", taddr, p);
		$display("test table done");
		bus(1'b0, 8'h40, 32'h00000000);
		chk("unmapped", rd, 32'h00000000);
		bus(1'b0, REG_CTRL, 32'h00000000);
		chk("ctrl", rd[0], 1'b1);
		bus(1'b1, REG_CTRL, 32'h00000000);
		m.send(16'h0f7f);
		#1;
		chk("valid", dec.valid, 1'b0);
		bus(1'b1, REG_CTRL, 32'h00000001);
		$display("test bus done");
		final_report();
	end
endmodule // ifd_decoder_bench
`default_nettype wire

// [sim/ifd_imem_model.sv]
// Program memory model: issues instruction words and answers table reads.
// Assumes the decoder samples words and table read data on sys_clk_i rising edges.
`timescale 1ns/10ps
`default_nettype none
module ifd_imem_model (
	// Clock.
	input wire logic sys_clk_i,
	// Table access from the decoder.
	input wire logic [ifd_pkg::PTR_W-1:0] tbl_addr_i,
	input wire logic tbl_rd_i,
	output logic [ifd_pkg::BYTE_W-1:0] tbl_rdata_o,
	// Instruction words out.
	output logic [ifd_pkg::WORD_W-1:0] word_o,
	output logic valid_o
);
	import ifd_pkg::*;
	logic [BYTE_W-1:0] last_q;
	initial begin
		word_o = 16'h0000;
		valid_o = 1'b0;
		last_q = 8'h00;
	end
	// Outside a read cycle the byte lane shows no stale data.
	always_comb begin
		tbl_rdata_o = tbl_rd_i ? (tbl_addr_i[7:0] ^ 8'h5a) : ~last_q;
	end
	always @(posedge sys_clk_i) begin
		if (tbl_rd_i) begin
			last_q <= tbl_rdata_o;
		end
	end
	// One word per strobe; the word lines are scrambled once released.
	task automatic send(input logic [WORD_W-1:0] w);
		@(posedge sys_clk_i);
		word_o <= w;
		valid_o <= 1'b1;
		@(posedge sys_clk_i);
		word_o <= ~w;
		valid_o <= 1'b0;
	endtask
endmodule // ifd_imem_model
`default_nettype wire
